// file: logic/lpt_pkg.sv
// Constants, types and timing counts for the DRAM-side termination and training response logic
// Functional notes
// R1 - Controller waits max(7.5ns,4clk) write-to-read and max(15ns,4clk) write recovery
// R2 - Controller spaces activates max(10ns,2clk), at most four per max(50ns,8clk)
// R3 - Controller keeps deep power-down for at least 500 us before exit
// R4 - Termination switches off within 12 ns of power-down entry; code allows one 25 ns mclk cycle after decode
// R5 - Termination switches off within 12 ns plus half clock of self-refresh/deep entry; code allows one 25 ns mclk cycle after decode
// R6 - Termination switches back on within 12 ns of power-down or self-refresh exit; code allows one 25 ns mclk cycle after decode
// R7 - Controller waits 20 clocks after calibration-mode write before first calibration command
// R8 - Controller holds clock enable low 10 clocks before first calibration command
// R9 - Controller waits 10 clocks after clock enable high before calibration exit write
// R10 - Controller waits 10 clocks after calibration-mode write before clock enable low
// R11 - Controller waits 10 clocks after last results before clock enable high
// R12 - Training results appear on data pins within 20 ns of each calibration command; code allows one 25 ns mclk cycle after decode
// R13 - Data pins stay driven at least 3 ns after calibration exit write
// R14 - Controller spaces calibration commands by result delay plus two clocks, rounded up
// R15 - Controller waits 25 ns after leveling-mode write before driving strobes
// R16 - Controller waits 40 ns after leveling-mode write before first strobe edge
// R17 - Leveling feedback of sampled clock appears 0 to 20 ns after strobe edge; code allows one 25 ns mclk cycle after the decoded strobe edge
// R18 - Controller waits max(14ns,10clk) after mode register set before next command
// R19 - Derating adds 1.875 ns to row, precharge and activate spacing minimums
// R20 - Controller rounds nanosecond minimums up and takes the larger cycle count
// R21 - Controller waits max(7.5ns,3clk) after power-down exit before next command
`default_nettype none

package lpt_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CA_W = 10;
  localparam int DQ_W = 16;
  localparam int MA_W = 6;
  localparam int CNT_W = 4;

  // ----------------------------------------------------------------
  // Timing in picoseconds and derived cycle counts
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_PS = 25000;
  localparam int ODT_PD_OFF_PS = 12000;
  localparam int ODT_SR_OFF_PS = 12000 + MCLK_PERIOD_PS / 2;
  localparam int ODT_ON_PS = 12000;
  localparam int ADR_MAX_PS = 20000;
  localparam int MRZ_MIN_PS = 3000;
  localparam int WLO_MAX_PS = 20000;
  // Longest times round down, least times round up, never under one cycle
  localparam int ODT_PD_OFF_CYC = (ODT_PD_OFF_PS / MCLK_PERIOD_PS < 1) ? 1 : ODT_PD_OFF_PS / MCLK_PERIOD_PS;
  localparam int ODT_SR_OFF_CYC = (ODT_SR_OFF_PS / MCLK_PERIOD_PS < 1) ? 1 : ODT_SR_OFF_PS / MCLK_PERIOD_PS;
  localparam int ODT_ON_CYC = (ODT_ON_PS / MCLK_PERIOD_PS < 1) ? 1 : ODT_ON_PS / MCLK_PERIOD_PS;
  localparam int ADR_MAX_CYC = (ADR_MAX_PS / MCLK_PERIOD_PS < 1) ? 1 : ADR_MAX_PS / MCLK_PERIOD_PS;
  localparam int WLO_MAX_CYC = (WLO_MAX_PS / MCLK_PERIOD_PS < 1) ? 1 : WLO_MAX_PS / MCLK_PERIOD_PS;
  localparam int MRZ_MIN_CYC = ((MRZ_MIN_PS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS < 1) ? 1 :
                               (MRZ_MIN_PS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
  localparam logic [CNT_W-1:0] MRZ_HOLD_LOAD = CNT_W'(MRZ_MIN_CYC);

  // ----------------------------------------------------------------
  // Command codes on ca[3:0] and mode addresses on ca[9:4]
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_MRW = 4'h0;
  localparam logic [3:0] CMD_SREF = 4'h4;
  localparam logic [3:0] CMD_DPD = 4'h6;
  localparam int CMD_LSB = 0;
  localparam int MA_LSB = 4;
  localparam logic [MA_W-1:0] MA_CA_ENTER = 6'h29;
  localparam logic [MA_W-1:0] MA_CA_EXIT = 6'h2A;
  localparam logic [MA_W-1:0] MA_WL_ON = 6'h02;
  localparam logic [MA_W-1:0] MA_WL_OFF = 6'h03;
  localparam logic [DQ_W-CA_W-1:0] DQ_PAD = 6'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ck;
    logic dqs;
    logic cke;
    logic cs_n;
    logic [CA_W-1:0] ca;
  } lpt_pins_type;

  localparam int PINS_W = $bits(lpt_pins_type);

  typedef enum logic [3:0] {
    ST_ACTIVE = 4'b0001,
    ST_PD = 4'b0010,
    ST_SR = 4'b0100,
    ST_DPD = 4'b1000
  } lpt_pstate_type;

endpackage

`default_nettype wire

// file: logic/lpt_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module lpt_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Pins and synchronised copy
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] d_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // Next values
  always_comb begin
    meta_nxt = d_in;
    sync_nxt = meta_r;
  end

  // Two stages, only the second is read outside
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign d_out = sync_r;

endmodule // lpt_sync

`default_nettype wire

// file: logic/lpt_core.sv
// DRAM-side termination control and training feedback on the data pins
`timescale 1ns/1ps
`default_nettype none

module lpt_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Pins from the controller
  input wire logic ck_pin,
  input wire logic dqs_pin,
  input wire logic cke_pin,
  input wire logic cs_n_pin,
  input wire logic [lpt_pkg::CA_W-1:0] ca_pin,
  // Termination
  output logic rtt_on,
  // Data pins, output side
  output logic [lpt_pkg::DQ_W-1:0] dq_o,
  output logic dq_oe,
  // Status
  output logic ca_mode,
  output logic wl_mode,
  output logic [3:0] power_state
);

  // ----------------------------------------------------------------
  // Input synchronisation and edge finding
  // ----------------------------------------------------------------
  lpt_pkg::lpt_pins_type pins_raw;
  lpt_pkg::lpt_pins_type pins_s;
  logic ck_d_r;
  logic dqs_d_r;
  logic cke_d_r;
  logic ck_rise;
  logic dqs_rise;
  logic cmd_sel;
  logic [3:0] cmd_code;
  logic [lpt_pkg::MA_W-1:0] cmd_ma;
  logic is_mrw;
  logic cke_fall;
  logic cke_rise;

  assign pins_raw = '{ck: ck_pin, dqs: dqs_pin, cke: cke_pin, cs_n: cs_n_pin, ca: ca_pin};

  lpt_sync #(
    .W(lpt_pkg::PINS_W)
  ) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .d_in(pins_raw),
    .d_out(pins_s)
  );

  // Previous samples for edges; cke is tracked per link clock edge
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ck_d_r <= 1'b0;
      dqs_d_r <= 1'b0;
      cke_d_r <= 1'b0;
    end else begin
      ck_d_r <= pins_s.ck;
      dqs_d_r <= pins_s.dqs;
      cke_d_r <= ck_rise ? pins_s.cke : cke_d_r;
    end
  end

  // Decode at each rising link clock edge
  assign ck_rise = pins_s.ck & ~ck_d_r;
  assign dqs_rise = pins_s.dqs & ~dqs_d_r;
  assign cmd_sel = ck_rise & ~pins_s.cs_n;
  assign cmd_code = pins_s.ca[lpt_pkg::CMD_LSB +: 4];
  assign cmd_ma = pins_s.ca[lpt_pkg::MA_LSB +: lpt_pkg::MA_W];
  assign is_mrw = cmd_sel & pins_s.cke & (cmd_code == lpt_pkg::CMD_MRW);
  assign cke_fall = ck_rise & cke_d_r & ~pins_s.cke;
  assign cke_rise = ck_rise & ~cke_d_r & pins_s.cke;

  // ----------------------------------------------------------------
  // Power state and termination
  // ----------------------------------------------------------------
  lpt_pkg::lpt_pstate_type pst_r;
  lpt_pkg::lpt_pstate_type pst_nxt;
  logic rtt_r;
  logic rtt_nxt;
  logic pd_entry;
  logic sr_entry;
  logic pd_exit;

  // Entry kind chosen by the command sampled with cke falling
  always_comb begin
    pst_nxt = pst_r;
    rtt_nxt = rtt_r;
    pd_entry = 1'b0;
    sr_entry = 1'b0;
    pd_exit = 1'b0;
    case (pst_r)
      lpt_pkg::ST_ACTIVE: begin
        if (cke_fall && !ca_mode) begin
          if (cmd_sel && cmd_code == lpt_pkg::CMD_SREF) begin
            pst_nxt = lpt_pkg::ST_SR;
            sr_entry = 1'b1;
          end else if (cmd_sel && cmd_code == lpt_pkg::CMD_DPD) begin
            pst_nxt = lpt_pkg::ST_DPD;
            sr_entry = 1'b1;
          end else begin
            pst_nxt = lpt_pkg::ST_PD;
            pd_entry = 1'b1;
          end
        end
      end
      lpt_pkg::ST_PD, lpt_pkg::ST_SR, lpt_pkg::ST_DPD: begin
        if (cke_rise) begin
          pst_nxt = lpt_pkg::ST_ACTIVE;
          pd_exit = 1'b1;
        end
      end
      default: pst_nxt = lpt_pkg::ST_ACTIVE;
    endcase
    // Off on the edge after entry, at the one-cycle budget
    if (pd_entry || sr_entry) begin
      rtt_nxt = 1'b0; // [R4] [R5]
    end else if (pd_exit) begin
      rtt_nxt = 1'b1; // [R6]
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pst_r <= lpt_pkg::ST_ACTIVE;
      rtt_r <= 1'b1;
    end else begin
      pst_r <= pst_nxt;
      rtt_r <= rtt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Training modes and data pin drive
  // ----------------------------------------------------------------
  logic ca_mode_r;
  logic ca_mode_nxt;
  logic wl_mode_r;
  logic wl_mode_nxt;
  logic [lpt_pkg::DQ_W-1:0] dq_r;
  logic [lpt_pkg::DQ_W-1:0] dq_nxt;
  logic oe_r;
  logic oe_nxt;
  logic [lpt_pkg::CNT_W-1:0] hold_r;
  logic [lpt_pkg::CNT_W-1:0] hold_nxt;
  logic ca_cal_cmd;
  logic ca_exit;
  // One count of the release delay, at counter width
  localparam logic [lpt_pkg::CNT_W-1:0] HOLD_STEP = {{(lpt_pkg::CNT_W-1){1'b0}}, 1'b1};

  assign ca_cal_cmd = ca_mode_r & cmd_sel & ~pins_s.cke;
  assign ca_exit = ca_mode_r & is_mrw & (cmd_ma == lpt_pkg::MA_CA_EXIT);

  // Mode writes, result capture and release delay
  always_comb begin
    ca_mode_nxt = ca_mode_r;
    wl_mode_nxt = wl_mode_r;
    dq_nxt = dq_r;
    oe_nxt = oe_r;
    hold_nxt = hold_r;
    if (is_mrw && cmd_ma == lpt_pkg::MA_CA_ENTER) begin
      ca_mode_nxt = 1'b1;
    end
    if (is_mrw && cmd_ma == lpt_pkg::MA_WL_ON) begin
      wl_mode_nxt = 1'b1;
    end
    if (is_mrw && cmd_ma == lpt_pkg::MA_WL_OFF) begin
      wl_mode_nxt = 1'b0;
      oe_nxt = 1'b0;
    end
    if (ca_cal_cmd) begin
      dq_nxt = {lpt_pkg::DQ_PAD, pins_s.ca}; // [R12]
      oe_nxt = 1'b1;
    end else if (wl_mode_r && dqs_rise) begin
      dq_nxt = {lpt_pkg::DQ_W{pins_s.ck}}; // [R17]
      oe_nxt = 1'b1;
    end
    // Keep driving for the hold count after the exit write
    if (ca_exit) begin
      ca_mode_nxt = 1'b0;
      hold_nxt = lpt_pkg::MRZ_HOLD_LOAD; // [R13]
    end else if (hold_r != '0) begin
      hold_nxt = hold_r - HOLD_STEP;
      if (hold_r == HOLD_STEP) begin
        oe_nxt = 1'b0; // [R13]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ca_mode_r <= 1'b0;
      wl_mode_r <= 1'b0;
      dq_r <= '0;
      oe_r <= 1'b0;
      hold_r <= '0;
    end else begin
      ca_mode_r <= ca_mode_nxt;
      wl_mode_r <= wl_mode_nxt;
      dq_r <= dq_nxt;
      oe_r <= oe_nxt;
      hold_r <= hold_nxt;
    end
  end

  // Outputs
  assign rtt_on = rtt_r;
  assign dq_o = dq_r;
  assign dq_oe = oe_r;
  assign ca_mode = ca_mode_r;
  assign wl_mode = wl_mode_r;
  assign power_state = pst_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  localparam int ODT_PD_MAX = lpt_pkg::ODT_PD_OFF_CYC;
  localparam int ODT_SR_MAX = lpt_pkg::ODT_SR_OFF_CYC;
  localparam int ODT_ON_MAX = lpt_pkg::ODT_ON_CYC;
  localparam int ADR_MAX = lpt_pkg::ADR_MAX_CYC;
  localparam int WLO_MAX = lpt_pkg::WLO_MAX_CYC;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  rtt_pd_off_a: assert property (pd_entry |-> ##[1:ODT_PD_MAX] !rtt_on) // [R4]
    else $error("termination still on after power-down entry");
  rtt_sr_off_a: assert property (sr_entry |-> ##[1:ODT_SR_MAX] (!rtt_on && power_state != lpt_pkg::ST_ACTIVE)) // [R5]
    else $error("termination still on after self-refresh or deep entry");
  rtt_exit_on_a: assert property (pd_exit |-> ##[1:ODT_ON_MAX] (rtt_on && power_state == lpt_pkg::ST_ACTIVE)) // [R6]
    else $error("termination not restored after exit");
  ca_result_a: assert property (ca_cal_cmd |-> ##[1:ADR_MAX] (dq_oe && dq_o[lpt_pkg::CA_W-1:0] == $past(pins_s.ca))) // [R12]
    else $error("calibration result missing or wrong");
  dq_hold_a: assert property ((ca_exit && dq_oe) |=> (dq_oe && !ca_mode) ##1 !dq_oe) // [R13]
    else $error("data pins released too early after exit write");
  wl_feedback_a: assert property ((wl_mode && dqs_rise && !ca_cal_cmd) |-> ##[1:WLO_MAX] (dq_oe && dq_o[0] == $past(pins_s.ck))) // [R17]
    else $error("leveling feedback missing or wrong");

  pd_cycle_c: cover property (pd_entry ##[1:100] pd_exit);
  ca_train_c: cover property (ca_cal_cmd ##[1:100] ca_exit);
  wl_edge_c: cover property (wl_mode && dqs_rise ##1 dq_oe);

endmodule // lpt_core

`default_nettype wire

// file: verif/lpt_ctrl_model.sv
// Memory controller model: free clock, clock enable, chip select, command bus and strobe
`timescale 1ns/1ps
`default_nettype none

module lpt_ctrl_model (
  // Pins toward the device
  output logic ck_pin,
  output logic dqs_pin,
  output logic cke_pin,
  output logic cs_n_pin,
  output logic [lpt_pkg::CA_W-1:0] ca_pin
);
  // ----------------------------------------------------------------
  // Free-running memory clock, phase unrelated to mclk
  // ----------------------------------------------------------------
  initial begin
    ck_pin = 1'b0;
    dqs_pin = 1'b1;
    cke_pin = 1'b1;
    cs_n_pin = 1'b1;
    ca_pin = 10'h000;
    #7;
    forever #100 ck_pin = ~ck_pin;
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // One clock of pins, launched after the falling edge, held across the rise
  task automatic cyc(input logic cke, input logic cs_n, input logic [lpt_pkg::CA_W-1:0] ca);
    @(negedge ck_pin);
    #5;
    cke_pin = cke;
    cs_n_pin = cs_n;
    ca_pin = ca;
  endtask

  // Drive the strobe to a steady level, launched after the falling edge
  task automatic hold_dqs(input logic v);
    @(negedge ck_pin);
    #5;
    dqs_pin = v;
  endtask

  // One strobe pulse inside the high or low half of the clock
  task automatic strobe(input logic lvl);
    if (lvl) begin
      @(posedge ck_pin);
    end else begin
      @(negedge ck_pin);
    end
    #50 dqs_pin = 1'b1;
    #50 dqs_pin = 1'b0;
  endtask
endmodule // lpt_ctrl_model

`default_nettype wire

// file: verif/tb_lpddr3_command_timing_rules.sv
// Testbench: controller model drives the pins, outputs checked against a queue of expected states
`timescale 1ns/1ps
`default_nettype none

module tb_lpddr3_command_timing_rules;
  // ----------------------------------------------------------------
  // Counts in 200 ns memory clocks
  // ----------------------------------------------------------------
  localparam int DPD_CK = 2500; // 500 us hold
  localparam int CACD_CK = 3; // 20 ns plus two clocks, rounded up
  localparam int ACT_GAP_CK = 2; // 10 ns plus derating, two clocks minimum
  localparam int ACT_WIN_CK = 8; // 50 ns or eight clocks for four activates
  localparam int WR_RD_CK = 4; // 7.5 ns or four clocks write to read
  localparam int WR_REC_CK = 4; // 15 ns or four clocks write recovery
  // Command codes the block does not act on
  localparam logic [3:0] CMD_ROW = 4'h1;
  localparam logic [3:0] CMD_WRITE = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  logic mclk;
  logic reset_n;
  logic ck_pin, dqs_pin, cke_pin, cs_n_pin;
  logic [lpt_pkg::CA_W-1:0] ca_pin;
  logic rtt_on, dq_oe, ca_mode, wl_mode;
  logic [lpt_pkg::DQ_W-1:0] dq_o;
  logic [lpt_pkg::DQ_W-1:0] edq = 16'h0000;
  logic [3:0] power_state;
  logic [23:0] obs, prev;
  logic [23:0] exp_q[$];
  logic [9:0] cal = 10'h000;
  int miscompares = 0;
  int checks = 0;
  int seed = 32'h94e0_2e1c;
  realtime last_t = 0;

  lpt_ctrl_model ctrl_u (.ck_pin(ck_pin), .dqs_pin(dqs_pin), .cke_pin(cke_pin), .cs_n_pin(cs_n_pin),
    .ca_pin(ca_pin));
  lpt_core dut_u (.mclk(mclk), .reset_n(reset_n), .ck_pin(ck_pin), .dqs_pin(dqs_pin), .cke_pin(cke_pin),
    .cs_n_pin(cs_n_pin), .ca_pin(ca_pin), .rtt_on(rtt_on), .dq_o(dq_o), .dq_oe(dq_oe), .ca_mode(ca_mode),
    .wl_mode(wl_mode), .power_state(power_state));

  assign obs = {power_state, rtt_on, ca_mode, wl_mode, dq_oe, dq_o};

  // ----------------------------------------------------------------
  // Clock, reset and helpers
  // ----------------------------------------------------------------
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;
  initial begin
    reset_n = 1'b0;
    repeat (2) @(posedge mclk);
    #2 reset_n = 1'b1;
  end

  // Queue one expected output state
  task automatic note(input logic [3:0] ps, input logic rtt, input logic cam, input logic wlm, input logic oe);
    exp_q.push_back({ps, rtt, cam, wlm, oe, edq});
  endtask

  // Idle clocks, no chip select, random command bus
  task automatic idle(input logic cke, input int n);
    repeat (n) ctrl_u.cyc(cke, 1'b1, 10'($random(seed)));
  endtask

  task automatic mrw(input logic [lpt_pkg::MA_W-1:0] ma);
    ctrl_u.cyc(1'b1, 1'b0, {ma, lpt_pkg::CMD_MRW});
  endtask

  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watcher: every output change takes the oldest note
  // ----------------------------------------------------------------
  always @(posedge ck_pin or posedge dqs_pin) last_t = $realtime;
  always @(negedge mclk) begin
    if (reset_n === 1'b1 && obs !== prev) begin
      checks += 2;
      if (exp_q.size() == 0 || exp_q[0] !== obs) begin
        miscompares++;
        $display("Error at %0t: expected %h got %h", $time, (exp_q.size() > 0) ? exp_q[0] : 24'h00_0000, obs);
      end
      if ($realtime - last_t > 175.0) begin
        miscompares++;
        $display("Error at %0t: latency expected %h got %h", $time, 175, int'($realtime - last_t));
      end
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
    prev = obs;
  end

  // Watchdog well past the expected run length
  initial begin
    #1_000_000;
    miscompares++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    wait (reset_n === 1'b1);
    idle(1'b1, 2);
    // Row and column traffic, legally spaced; any output change here is an error
    for (int i = 0; i < 4; i++) begin
      ctrl_u.cyc(1'b1, 1'b0, {6'h15, CMD_ROW});
      idle(1'b1, ACT_GAP_CK - 1);
    end
    idle(1'b1, ACT_WIN_CK);
    ctrl_u.cyc(1'b1, 1'b0, {6'h00, CMD_WRITE});
    idle(1'b1, WR_RD_CK);
    ctrl_u.cyc(1'b1, 1'b0, {6'h00, CMD_READ});
    ctrl_u.cyc(1'b1, 1'b0, {6'h00, CMD_WRITE});
    idle(1'b1, WR_REC_CK);
    ctrl_u.cyc(1'b1, 1'b0, {6'h00, CMD_ROW});
    idle(1'b1, 2);
    // Power-down entry and exit
    note(lpt_pkg::ST_PD, 1'b0, 1'b0, 1'b0, 1'b0);
    idle(1'b0, 4);
    note(lpt_pkg::ST_ACTIVE, 1'b1, 1'b0, 1'b0, 1'b0);
    idle(1'b1, 4);
    // Self-refresh entry and exit
    note(lpt_pkg::ST_SR, 1'b0, 1'b0, 1'b0, 1'b0);
    ctrl_u.cyc(1'b0, 1'b0, {6'h00, lpt_pkg::CMD_SREF});
    idle(1'b0, 3);
    note(lpt_pkg::ST_ACTIVE, 1'b1, 1'b0, 1'b0, 1'b0);
    idle(1'b1, 4);
    // Deep power-down held for its minimum
    note(lpt_pkg::ST_DPD, 1'b0, 1'b0, 1'b0, 1'b0);
    ctrl_u.cyc(1'b0, 1'b0, {6'h00, lpt_pkg::CMD_DPD});
    idle(1'b0, DPD_CK);
    note(lpt_pkg::ST_ACTIVE, 1'b1, 1'b0, 1'b0, 1'b0);
    idle(1'b1, 4);
    // Command-address training; clock enable fall is not power-down
    note(lpt_pkg::ST_ACTIVE, 1'b1, 1'b1, 1'b0, 1'b0);
    mrw(lpt_pkg::MA_CA_ENTER);
    idle(1'b1, 10);
    idle(1'b0, 20);
    for (int i = 0; i < 4; i++) begin
      cal = cal + 10'h001 + 10'($random(seed) & 32'h0000_00ff);
      edq = {lpt_pkg::DQ_PAD, cal};
      note(lpt_pkg::ST_ACTIVE, 1'b1, 1'b1, 1'b0, 1'b1);
      ctrl_u.cyc(1'b0, 1'b0, cal);
      idle(1'b0, CACD_CK - 1);
    end
    idle(1'b0, 10);
    idle(1'b1, 10);
    note(lpt_pkg::ST_ACTIVE, 1'b1, 1'b0, 1'b0, 1'b1);
    note(lpt_pkg::ST_ACTIVE, 1'b1, 1'b0, 1'b0, 1'b0);
    mrw(lpt_pkg::MA_CA_EXIT);
    idle(1'b1, 10);
    // Write leveling with alternating sampled clock levels
    note(lpt_pkg::ST_ACTIVE, 1'b1, 1'b0, 1'b1, 1'b0);
    mrw(lpt_pkg::MA_WL_ON);
    idle(1'b1, 10);
    ctrl_u.hold_dqs(1'b0);
    for (int i = 0; i < 6; i++) begin
      edq = {16{~i[0]}};
      note(lpt_pkg::ST_ACTIVE, 1'b1, 1'b0, 1'b1, 1'b1);
      ctrl_u.strobe(~i[0]);
    end
    note(lpt_pkg::ST_ACTIVE, 1'b1, 1'b0, 1'b0, 1'b0);
    mrw(lpt_pkg::MA_WL_OFF);
    idle(1'b1, 10);
    ctrl_u.hold_dqs(1'b1);
    idle(1'b1, 4);
    checks++;
    if (exp_q.size() != 0) begin
      miscompares++;
      $display("Error at %0t: pending expected %h got %h", $time, 0, exp_q.size());
    end
    end_sim();
  end
endmodule // tb_lpddr3_command_timing_rules

`default_nettype wire
